// File: hsl_loop_ctrl.sv
// smart-loop actuator control: resonance tracking, open-loop fallback, feedback gain, level calibration
`default_nettype none
module hsl_loop_ctrl #(
  parameter int unsigned HALF_TICK_CYCLES = hsl_pkg::HALF_TICK_CYC,
  parameter logic [6:0]  SLAVE_ADDR       = 7'h48  // arbitrary bus address
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       bemf_zc_in,
  input  wire logic [7:0] bemf_level_in,
  input  wire logic [7:0] input_level_in,
  output logic [7:0]      drive_level_out,
  output logic            drive_polarity_out,
  output logic            sample_strobe_out,
  output logic            open_loop_out,
  output logic            braking_out
);
  import hsl_pkg::*;

  // signed saturation to the 8-bit drive range
  function automatic logic [7:0] sat8(input logic signed [12:0] v);
    if (v < 13'sd0) begin
      sat8 = 8'h00;
    end else if (v > 13'sd255) begin
      sat8 = 8'hff;
    end else begin
      sat8 = v[7:0];
    end
  endfunction

  function automatic logic signed [12:0] sx(input logic [7:0] v);
    sx = $signed({5'b00000, v});
  endfunction

  // zero-cross detect time in half ticks
  function automatic logic [4:0] zc_ticks(input logic [1:0] sel);
    zc_ticks = {3'b000, sel} + 5'h01;
  endfunction

  function automatic logic [7:0] cal_ticks(input logic [1:0] sel);
    case (sel)
      2'h0:    cal_ticks = CAL_TICKS_0;
      2'h1:    cal_ticks = CAL_TICKS_1;
      2'h2:    cal_ticks = CAL_TICKS_2;
      default: cal_ticks = CAL_TICKS_3;
    endcase
  endfunction

  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;

  logic [1:0]  run_ctrl_r;
  logic [7:0]  rated_r;
  logic [7:0]  clamp_r;
  logic [7:0]  comp_r;
  logic [7:0]  bemf_norm_r;
  logic [7:0]  fb_ctrl_r;
  logic [7:0]  drive_timing_r;
  logic [7:0]  loop_extra_r;
  logic [7:0]  loop_opts_r;
  logic [6:0]  fb_period_r;
  logic [7:0]  res_period_r;
  logic        cal_busy_r;
  logic [7:0]  cal_cnt_r;

  logic [15:0] div_cnt_r;
  logic        tick;
  logic [1:0]  zc_sync_r;
  logic        zc_prev_r;
  logic        zc_event;

  hsl_mode_e   mode_r;
  logic [7:0]  half_cnt_r;
  logic [1:0]  unsync_cnt_r;
  logic        synced_r;
  logic        pol_r;
  logic        sample_tgl_r;
  logic [7:0]  halves_r;
  logic        commutate;

  logic        is_lra;
  logic        active;
  logic [7:0]  default_half;
  logic [7:0]  target;
  logic [15:0] target_prod;
  logic [7:0]  bemf_adj;
  logic signed [12:0] err;
  logic [1:0]  shift;
  logic        braking;
  logic [11:0] brake_mag;
  logic [7:0]  level;

  hsl_i2c_slave #(
    .SLAVE_ADDR (SLAVE_ADDR)
  ) u_port (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_out     (sda_out),
    .sda_oe_out  (sda_oe_out),
    .wr_stb_out  (wr_stb),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .rd_addr_out (rd_addr),
    .rd_data_in  (rd_data)
  );

  assign is_lra = fb_ctrl_r[FB_TYPE_BIT];
  assign active = run_ctrl_r[0] | cal_busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // host-written registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_ctrl_r     <= 2'b00;
      rated_r        <= RST_RATED;
      clamp_r        <= RST_CLAMP;
      fb_ctrl_r      <= RST_FB_CTRL;
      drive_timing_r <= RST_DRIVE_TIMING;
      loop_extra_r   <= RST_LOOP_EXTRA;
      loop_opts_r    <= RST_LOOP_OPTS;
      fb_period_r    <= RST_FB_PERIOD[6:0];
    end else if (wr_stb) begin
      case (wr_addr)
        REG_RUN_CTRL:     run_ctrl_r     <= wr_data[1:0];
        REG_RATED_LEVEL:  rated_r        <= wr_data;
        REG_CLAMP_LEVEL:  clamp_r        <= wr_data;
        REG_FB_CTRL:      fb_ctrl_r      <= wr_data;
        REG_DRIVE_TIMING: drive_timing_r <= wr_data;
        REG_LOOP_EXTRA:   loop_extra_r   <= wr_data;
        REG_LOOP_OPTS:    loop_opts_r    <= wr_data;
        REG_FB_PERIOD:    fb_period_r    <= wr_data[6:0];
        default: ;
      endcase
    end else begin
      run_ctrl_r[1] <= 1'b0;  // calibrate request is a one-shot
    end
  end

  always_comb begin
    case (rd_addr)
      REG_STATUS:       rd_data = {4'h0, cal_busy_r, mode_r == ST_AUTO_OL, mode_r != ST_CLOSED, synced_r};
      REG_RUN_CTRL:     rd_data = {6'h00, run_ctrl_r};
      REG_RATED_LEVEL:  rd_data = rated_r;
      REG_CLAMP_LEVEL:  rd_data = clamp_r;
      REG_COMP_FACTOR:  rd_data = comp_r;
      REG_BEMF_NORM:    rd_data = bemf_norm_r;
      REG_FB_CTRL:      rd_data = fb_ctrl_r;
      REG_DRIVE_TIMING: rd_data = drive_timing_r;
      REG_LOOP_EXTRA:   rd_data = loop_extra_r;
      REG_LOOP_OPTS:    rd_data = loop_opts_r;
      REG_FB_PERIOD:    rd_data = {1'b0, fb_period_r};
      REG_RES_PERIOD:   rd_data = res_period_r;
      default:          rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-tick enable and zero-cross edge
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= 16'h0000;
    end else if (div_cnt_r == 16'(HALF_TICK_CYCLES - 1)) begin
      div_cnt_r <= 16'h0000;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  assign tick = (div_cnt_r == 16'(HALF_TICK_CYCLES - 1));

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zc_sync_r <= 2'b00;
      zc_prev_r <= 1'b0;
    end else begin
      zc_sync_r <= {zc_sync_r[0], bemf_zc_in};
      zc_prev_r <= zc_sync_r[1];
    end
  end

  // comparator output toggles at each back-EMF zero crossing
  assign zc_event = zc_sync_r[1] ^ zc_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // resonance tracker and open-loop fallback; calibration factors never enter here
  always_comb begin
    if (drive_timing_r[4:0] > zc_ticks(loop_extra_r[LX_ZCDT_LSB +: 2])) begin
      default_half = {3'b000, drive_timing_r[4:0] - zc_ticks(loop_extra_r[LX_ZCDT_LSB +: 2])};
    end else begin
      default_half = 8'h01;
    end
  end

  always_comb begin
    commutate = 1'b0;
    if (active && is_lra && mode_r != ST_IDLE) begin
      case (mode_r)
        ST_CLOSED:   commutate = zc_event || (tick && half_cnt_r >= {default_half[6:0], 1'b0});
        ST_FALLBACK: commutate = zc_event || (tick && half_cnt_r >= default_half);
        ST_AUTO_OL:  commutate = tick && half_cnt_r >= {1'b0, fb_period_r};
        default:     commutate = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r       <= ST_IDLE;
      half_cnt_r   <= 8'h00;
      unsync_cnt_r <= 2'b00;
      synced_r     <= 1'b0;
      res_period_r <= 8'h00;
    end else if (!active) begin
      mode_r       <= ST_IDLE;
      half_cnt_r   <= 8'h00;
      unsync_cnt_r <= 2'b00;
      synced_r     <= 1'b0;
    end else begin
      if (commutate) begin
        // a tick on the commutation edge still belongs to the new half cycle
        half_cnt_r <= {7'h00, tick};
      end else if (tick && half_cnt_r != 8'hff) begin
        half_cnt_r <= half_cnt_r + 8'h01;
      end
      case (mode_r)
        ST_IDLE: mode_r <= ST_CLOSED;
        ST_CLOSED, ST_FALLBACK: begin
          if (is_lra && zc_event) begin
            // half a drive cycle in half ticks equals the full period in 98.49 us units
            res_period_r <= (half_cnt_r == 8'h00) ? 8'h01 : half_cnt_r;
            synced_r     <= 1'b1;
            unsync_cnt_r <= 2'b00;
            mode_r       <= ST_CLOSED;
          end else if (commutate) begin
            synced_r <= 1'b0;
            if (loop_opts_r[LO_AUTO_BIT] &&
                unsync_cnt_r >= loop_opts_r[LO_LIMIT_LSB +: 2]) begin
              mode_r <= ST_AUTO_OL;
            end else begin
              mode_r <= ST_FALLBACK;
              if (unsync_cnt_r != 2'b11) begin
                unsync_cnt_r <= unsync_cnt_r + 2'b01;
              end
            end
          end
        end
        ST_AUTO_OL: synced_r <= 1'b0;  // stays until drive stops, never resyncs
        default: mode_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive polarity, boost window and back-EMF sampling
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pol_r        <= 1'b0;
      sample_tgl_r <= 1'b0;
      halves_r     <= 8'h00;
    end else if (!active) begin
      pol_r        <= 1'b0;
      sample_tgl_r <= 1'b0;
      halves_r     <= 8'h00;
    end else if (commutate) begin
      pol_r        <= ~pol_r;
      sample_tgl_r <= ~sample_tgl_r;
      if (halves_r != 8'hff) begin
        halves_r <= halves_r + 8'h01;
      end
    end else if (!is_lra && tick && halves_r != 8'hff) begin
      halves_r <= halves_r + 8'h01;  // ERM startup window counts in ticks
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_strobe_out <= 1'b0;
    end else begin
      sample_strobe_out <= commutate && (loop_extra_r[LX_DBL_BIT] || sample_tgl_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // feedback level path
  assign target_prod = (cal_busy_r ? 8'hff : input_level_in) * rated_r;
  assign target      = target_prod[15:8];

  always_comb begin
    // normalization moves the measured back-EMF at rated drive onto the rated level
    bemf_adj  = sat8(sx(bemf_level_in) + sx(rated_r) - sx(bemf_norm_r));
    err       = sx(target) - sx(bemf_adj);
    braking   = (mode_r == ST_CLOSED) && (target == 8'h00) && (bemf_adj != 8'h00);
    shift     = 2'd3 - fb_ctrl_r[FB_GAIN_LSB +: 2];
    if (drive_timing_r[DT_BOOST_BIT] && halves_r < BOOST_HALVES && shift != 2'd0) begin
      shift = shift - 2'd1;
    end
    if (braking && loop_extra_r[LX_STAB_BIT] && bemf_adj < STAB_LEVEL && shift != 2'd3) begin
      shift = shift + 2'd1;
    end
    brake_mag = 12'(bemf_adj) * {9'h000, fb_ctrl_r[FB_RATIO_LSB +: 3]} + 12'(bemf_adj);
    if (!active || mode_r == ST_IDLE) begin
      level = 8'h00;
    end else if (mode_r != ST_CLOSED) begin
      level = sat8(sx(target) + sx(comp_r));
    end else if (braking) begin
      level = sat8($signed({1'b0, brake_mag >> shift}));
    end else begin
      level = sat8(sx(target) + (err >>> shift) + sx(comp_r));
    end
    if (level > clamp_r) begin
      level = clamp_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive_level_out    <= 8'h00;
      drive_polarity_out <= 1'b0;
      open_loop_out      <= 1'b0;
      braking_out        <= 1'b0;
    end else begin
      drive_level_out    <= level;
      drive_polarity_out <= is_lra ? (pol_r ^ braking) : braking;
      open_loop_out      <= active && (mode_r == ST_FALLBACK || mode_r == ST_AUTO_OL);
      braking_out        <= braking && active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level calibration: drive rated level, then capture both factors at the end only
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_busy_r  <= 1'b0;
      cal_cnt_r   <= 8'h00;
      comp_r      <= RST_COMP;
      bemf_norm_r <= RST_RATED;
    end else if (!cal_busy_r) begin
      if (run_ctrl_r[1]) begin
        cal_busy_r <= 1'b1;
        cal_cnt_r  <= 8'h00;
      end
    end else if (tick) begin
      if (cal_cnt_r >= cal_ticks(loop_extra_r[LX_CALT_LSB +: 2])) begin
        cal_busy_r  <= 1'b0;
        bemf_norm_r <= (bemf_level_in == 8'h00) ? 8'h01 : bemf_level_in;
        comp_r      <= (level > rated_r) ? level - rated_r : 8'h00;
      end else begin
        cal_cnt_r <= cal_cnt_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: hsl_pkg.sv
// constants, register map and types for the haptic smart-loop control block
//
// How it works
// - LRA tracker locks on the first zero cross and follows every half cycle
// - tracked resonance period is readable over the serial port while synchronized
// - invalid back-EMF makes the LRA fall back to open-loop drive at default frequency
// - a returning zero cross during fallback hands control back to the tracker
// - default fallback half period is drive time minus zero-cross detect time
// - auto fallback enable moves to fixed open loop only on sync failure, no resync
// - two-bit limit sets how many unsynchronized half cycles are tolerated first
// - fixed open-loop period is the seven-bit field times 98.49 us
// - open-loop drive applies no feedback overdrive and no feedback braking
// - startup boost raises loop gain during the first half cycles
// - three-bit brake ratio scales braking gain against driving gain
// - brake stabilizer lowers loop gain as braking nears completion
// - full-scale input gives rated level; feedback never exceeds the clamp
// - calibration stores an eight-bit resistive-loss compensation factor
// - calibration stores an eight-bit back-EMF normalization factor
// - two-bit calibration time selects the calibration duration
// - two-bit loop gain sets how fast feedback pulls back-EMF to the input
// - tracker needs no calibration and ignores calibration results
// - LRA back-EMF sampled once per period, twice when double sampling is set; no sample strobe for ERM
// - fallback period field lives in the register at 0x20
`default_nettype none
package hsl_pkg;
  // register offsets
  localparam logic [7:0] REG_STATUS       = 8'h00;
  localparam logic [7:0] REG_RUN_CTRL     = 8'h01;
  localparam logic [7:0] REG_RATED_LEVEL  = 8'h16;
  localparam logic [7:0] REG_CLAMP_LEVEL  = 8'h17;
  localparam logic [7:0] REG_COMP_FACTOR  = 8'h18;
  localparam logic [7:0] REG_BEMF_NORM    = 8'h19;
  localparam logic [7:0] REG_FB_CTRL      = 8'h1a;
  localparam logic [7:0] REG_DRIVE_TIMING = 8'h1b;
  localparam logic [7:0] REG_LOOP_EXTRA   = 8'h1c;
  localparam logic [7:0] REG_LOOP_OPTS    = 8'h1f;
  localparam logic [7:0] REG_FB_PERIOD    = 8'h20;
  localparam logic [7:0] REG_RES_PERIOD   = 8'h22;
  // reset values
  localparam logic [7:0] RST_RATED        = 8'h3f;
  localparam logic [7:0] RST_CLAMP        = 8'hff;
  localparam logic [7:0] RST_COMP         = 8'h00;
  localparam logic [7:0] RST_FB_CTRL      = 8'h24;
  localparam logic [7:0] RST_DRIVE_TIMING = 8'h13;
  localparam logic [7:0] RST_LOOP_EXTRA   = 8'h14;
  localparam logic [7:0] RST_LOOP_OPTS    = 8'h40;
  localparam logic [7:0] RST_FB_PERIOD    = 8'h33;
  // field positions
  localparam int FB_TYPE_BIT   = 7;
  localparam int FB_RATIO_LSB  = 4;
  localparam int FB_GAIN_LSB   = 2;
  localparam int DT_BOOST_BIT  = 7;
  localparam int LX_STAB_BIT   = 6;
  localparam int LX_CALT_LSB   = 4;
  localparam int LX_ZCDT_LSB   = 2;
  localparam int LX_DBL_BIT    = 0;
  localparam int LO_LIMIT_LSB  = 6;
  localparam int LO_AUTO_BIT   = 5;
  // timing: one tick is half of the 98.49 us open-loop period unit
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned HALF_TICK_PS   = 49245000;
  localparam int unsigned HALF_TICK_CYC  = HALF_TICK_PS / CLK_PERIOD_PS;
  localparam logic [7:0]  BOOST_HALVES   = 8'h04;
  localparam logic [7:0]  STAB_LEVEL     = 8'h10;
  localparam logic [7:0]  CAL_TICKS_0    = 8'h14;
  localparam logic [7:0]  CAL_TICKS_1    = 8'h28;
  localparam logic [7:0]  CAL_TICKS_2    = 8'h50;
  localparam logic [7:0]  CAL_TICKS_3    = 8'ha0;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0001,
    ST_CLOSED   = 4'b0010,
    ST_FALLBACK = 4'b0100,
    ST_AUTO_OL  = 4'b1000
  } hsl_mode_e;

  typedef enum logic [8:0] {
    I2_IDLE  = 9'b000000001,
    I2_ADDR  = 9'b000000010,
    I2_ACK_A = 9'b000000100,
    I2_PTR   = 9'b000001000,
    I2_ACK_P = 9'b000010000,
    I2_WDATA = 9'b000100000,
    I2_ACK_W = 9'b001000000,
    I2_RDATA = 9'b010000000,
    I2_ACK_R = 9'b100000000
  } hsl_i2c_e;
endpackage
`default_nettype wire

// File: hsl_i2c_slave.sv
// serial two-wire register port: pointer write, data write and read with auto-increment
`default_nettype none
module hsl_i2c_slave #(
  parameter logic [6:0] SLAVE_ADDR = 7'h48  // arbitrary bus address
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            wr_stb_out,
  output logic [7:0]      wr_addr_out,
  output logic [7:0]      wr_data_out,
  output logic [7:0]      rd_addr_out,
  input  wire logic [7:0] rd_data_in
);
  import hsl_pkg::*;

  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  hsl_i2c_e   state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic       read_r;
  logic       nack_r;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;

  ////////////////////////////////////////////////////////////////////////////
  // two flops before anything looks at the pins; bit 2 is the edge history
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end

  assign start_det = scl_sync_r[1] & sda_sync_r[2] & ~sda_sync_r[1];
  assign stop_det  = scl_sync_r[1] & ~sda_sync_r[2] & sda_sync_r[1];
  assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r     <= I2_IDLE;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      ptr_r       <= 8'h00;
      read_r      <= 1'b0;
      nack_r      <= 1'b0;
      wr_stb_out  <= 1'b0;
      wr_addr_out <= 8'h00;
      wr_data_out <= 8'h00;
    end else begin
      wr_stb_out <= 1'b0;
      if (start_det) begin
        state_r   <= I2_ADDR;
        bit_cnt_r <= 4'h0;
      end else if (stop_det) begin
        state_r <= I2_IDLE;
      end else if (scl_rise) begin
        case (state_r)
          I2_ADDR, I2_PTR, I2_WDATA: begin
            shift_r   <= {shift_r[6:0], sda_sync_r[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          I2_RDATA: bit_cnt_r <= bit_cnt_r + 4'h1;
          I2_ACK_R: nack_r <= sda_sync_r[1];
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_r)
          I2_ADDR: if (bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            read_r    <= shift_r[0];
            state_r   <= (shift_r[7:1] == SLAVE_ADDR) ? I2_ACK_A : I2_IDLE;
          end
          I2_PTR: if (bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            ptr_r     <= shift_r;
            state_r   <= I2_ACK_P;
          end
          I2_WDATA: if (bit_cnt_r == 4'h8) begin
            bit_cnt_r   <= 4'h0;
            wr_stb_out  <= 1'b1;
            wr_addr_out <= ptr_r;
            wr_data_out <= shift_r;
            ptr_r       <= ptr_r + 8'h01;
            state_r     <= I2_ACK_W;
          end
          I2_ACK_A: begin
            if (read_r) begin
              shift_r <= rd_data_in;
              state_r <= I2_RDATA;
            end else begin
              state_r <= I2_PTR;
            end
          end
          I2_ACK_P, I2_ACK_W: state_r <= I2_WDATA;
          I2_RDATA: begin
            if (bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              ptr_r     <= ptr_r + 8'h01;
              state_r   <= I2_ACK_R;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
            end
          end
          I2_ACK_R: begin
            if (nack_r) begin
              state_r <= I2_IDLE;
            end else begin
              shift_r <= rd_data_in;
              state_r <= I2_RDATA;
            end
          end
          default: state_r <= I2_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open drain: only ever pull low, from a flop so the line never glitches
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_oe_out <= 1'b0;
    end else begin
      sda_oe_out <= (state_r == I2_ACK_A) || (state_r == I2_ACK_P) || (state_r == I2_ACK_W) ||
                    ((state_r == I2_RDATA) && !shift_r[7]);
    end
  end

  assign sda_out     = 1'b0;
  assign rd_addr_out = ptr_r;
endmodule
`default_nettype wire

// File: hsl_checker.sv
// assertions on the ports of the loop control block
`default_nettype none
module hsl_checker (
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic [7:0] drive_level_out,
  input wire logic       drive_polarity_out,
  input wire logic       sample_strobe_out,
  input wire logic       open_loop_out,
  input wire logic       braking_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sda_low_a: assert property (sda_out == 1'b0) else $error("sda data not low");
  ack_rise_a: assert property ($rose(sda_oe_out) |-> !scl_in) else $error("ack raised in scl high");
  ack_fall_a: assert property ($fell(sda_oe_out) |-> !scl_in) else $error("ack dropped in scl high");
  ol_no_brake_a: assert property (open_loop_out |-> !braking_out) else $error("brake in open loop");
  strobe_pulse_a: assert property (sample_strobe_out |=> !sample_strobe_out) else $error("strobe too long");
  ol_hold_a: assert property ($rose(open_loop_out) |-> open_loop_out[*2]) else $error("fallback glitch");
  pol_hold_a: assert property ($changed(drive_polarity_out) |=> $stable(drive_polarity_out)[*2])
    else $error("polarity chatter");
  idle_start_a: assert property ($rose(rst_n_in) |-> (drive_level_out == 8'h00)[*4])
    else $error("drive before run");
  cover property ($rose(open_loop_out));
  cover property ($fell(open_loop_out));
  cover property (sample_strobe_out);
endmodule
`default_nettype wire

// File: hsl_actuator_model.sv
// actuator model: back-EMF zero crossings at a fixed half period while driven
`default_nettype none
module hsl_actuator_model #(
  parameter int HALF = 40
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] drive_in,
  input  wire logic       mute_in,
  output logic            zc_out,
  output logic [7:0]      level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // a stalled actuator gives no crossings and no amplitude
  assign level_out = mute_in ? 8'h00 : 8'h40;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      zc_out <= 1'b0;
    end else if (drive_in != 8'h00 && !mute_in) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) zc_out <= ~zc_out;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench: register port, tracking, fallback, fixed open loop
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, scl, sda_m, sda_oe, zc, ol, brk, mute;
  logic [7:0] bl, dl;
  int fail_count, samples_checked;
  wire sda_w = sda_m & ~sda_oe;
  hsl_loop_ctrl #(.HALF_TICK_CYCLES(4)) dut (.sys_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl),
    .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe), .bemf_zc_in(zc), .bemf_level_in(bl),
    .input_level_in(8'hff), .drive_level_out(dl), .drive_polarity_out(), .sample_strobe_out(),
    .open_loop_out(ol), .braking_out(brk));
  hsl_actuator_model act (.clk_in(clk), .rst_n_in(rst_n), .drive_in(dl), .mute_in(mute),
    .zc_out(zc), .level_out(bl));
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %0t %s got %h", $time, m, got);
      fail_count++;
    end
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    tick(8);
    scl <= 1'b1;
    tick(8);
    r = sda_w;
    tick(8);
    scl <= 1'b0;
    tick(8);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q);
    logic k;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(mack, k);
  endtask
  // doubles as repeated start because sda is raised before scl
  task automatic start();
    sda_m <= 1'b1;
    tick(8);
    scl <= 1'b1;
    tick(8);
    sda_m <= 1'b0;
    tick(8);
    scl <= 1'b0;
    tick(8);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    tick(8);
    scl <= 1'b1;
    tick(8);
    sda_m <= 1'b1;
    tick(8);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer(8'h90, 1'b1, q);
    xfer(a, 1'b1, q);
    xfer(d, 1'b1, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    start();
    xfer(8'h90, 1'b1, q);
    xfer(a, 1'b1, q);
    start();
    xfer(8'h91, 1'b1, q);
    xfer(8'hff, 1'b1, q);
    stop();
    chk(q, e, "register read");
  endtask
  task automatic wait_ol(input logic v);
    int i;
    for (i = 0; i < 5000 && ol !== v; i++) tick(1);
    chk({7'h0, ol}, {7'h0, v}, "open loop flag");
    if (i == 5000) give_verdict();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic test_regs();
    rd(8'h1a, 8'h24);
    rd(8'h1f, 8'h40);
    rd(8'h20, 8'h33);
    rd(8'h05, 8'h00);
    wr(8'h20, 8'h45);
    rd(8'h20, 8'h45);
    $display("test regs done");
  endtask
  task automatic test_track();
    wr(8'h1a, 8'ha4);
    wr(8'h01, 8'h01);
    tick(600);
    chk({7'h0, ol}, 8'h00, "tracking lost");
    // poll only while in sync, never idle or braking
    rd(8'h22, 8'h0a);
    $display("test track done");
  endtask
  task automatic test_fallback();
    mute <= 1'b1;
    wait_ol(1'b1);
    chk({7'h0, brk}, 8'h00, "brake in fallback");
    mute <= 1'b0;
    wait_ol(1'b0);
    $display("test fallback done");
  endtask
  task automatic test_auto();
    wr(8'h01, 8'h00);
    wr(8'h1f, 8'h20);
    wr(8'h01, 8'h01);
    mute <= 1'b1;
    wait_ol(1'b1);
    mute <= 1'b0;
    tick(400);
    chk({7'h0, ol}, 8'h01, "resync in fixed open loop");
    wr(8'h01, 8'h00);
    $display("test auto done");
  endtask
  // normalization settles on the actuator's back-EMF at rated drive, compensation on the excess
  task automatic test_cal();
    wr(8'h01, 8'h02);
    tick(400);
    rd(8'h19, 8'h40);
    rd(8'h18, 8'h00);
    $display("test cal done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_n, scl, sda_m, mute} = 4'b0110;
    fail_count = 0;
    samples_checked = 0;
    tick(5);
    rst_n <= 1'b1;
    tick(4);
    test_regs();
    test_track();
    test_fallback();
    test_auto();
    test_cal();
    give_verdict();
  end
endmodule
bind hsl_loop_ctrl hsl_checker chk_i (.*);
`default_nettype wire
